// ==== rtl/ulmds_pkg.sv ====
//
// Behaviour
// R1 - Receive FIFO error bit 0 set while errored characters held; clears on read when none.
// R2 - Transmitter empty bit 1 reads 1 only when holding stage and shifter empty.
// R3 - Holding empty bit 2 set once holding stage (or transmit FIFO) is empty.
// R4 - Break bit 3 set when input stays low beyond one whole frame.
// R5 - After break, wait for high then valid start; store one zero character.
// R6 - Break bit clears on status read or on a frame with good stop.
// R7 - Framing error bit 4 from first stop sample; flagged at FIFO head.
// R8 - After framing error, low stop sample is taken as next start bit.
// R9 - Framing error bit clears on status read or new buffer load.
// R10 - Parity error bit 5 on mismatch, at head; clears on read or load.
// R11 - Non-FIFO overrun bit 6 when unread buffer overwritten; clears on status read.
// R12 - FIFO overrun when full and another character completes; FIFO kept intact.
// R13 - Data ready bit 7 while buffer or FIFO holds a character.
// R14 - Modem status bit 3 is inverse of active-low clear-to-send input.
// R15 - Modem status bit 7 set on clear-to-send change; raises enabled interrupt.
// R16 - Eight-bit scratch register, read/write, no effect on serial operation.
// R17 - DMA mode 1 only when mode select and FIFO enable both set.
// R18 - Mode 0 transmit-ready set while transmit stage holds a character.
// R19 - Mode 1 transmit-ready set when transmit FIFO full, cleared when empty.
// R20 - Mode 0 receive-ready set when no received character is held.
// R21 - Mode 1 receive-ready clears at trigger or timeout until FIFO empties.
// R22 - Software should read line status before the received character.
// R23 - Trigger field: 00 one, 01 four, 10 eight, 11 fourteen bytes.
// R24 - Timeout after four character times without FIFO traffic while non-empty.
package ulmds_pkg;
	// ********************************************************
	// Register map
	// ********************************************************
	localparam logic [11:0] OFF_RBR  = 12'h000;
	localparam logic [11:0] OFF_LSR  = 12'h004;
	localparam logic [11:0] OFF_MSR  = 12'h008;
	localparam logic [11:0] OFF_SCR  = 12'h00c;
	localparam logic [11:0] OFF_DSR  = 12'h010;
	localparam logic [11:0] OFF_CFG  = 12'h014;
	localparam int          MSR_CTS  = 3;
	localparam int          MSR_CLEAR_TO_SEND_CHANGED = 7;
	localparam int          DSR_TX   = 6;
	localparam int          DSR_RX   = 7;
	localparam logic [7:0]  SCR_RST  = 8'h00;
	localparam logic [9:0]  CFG_RST  = 10'h000;

	// ********************************************************
	// Sizes and timing
	// ********************************************************
	localparam int          FIFO_DEPTH    = 16;
	localparam logic [4:0]  FIFO_FULL     = 5'h10;
	localparam logic [4:0]  NOFIFO_DEPTH  = 5'h01;
	localparam logic [3:0]  TICK_MID      = 4'h7;
	localparam logic [3:0]  TICK_LAST     = 4'hf;
	localparam int          OVERSAMPLE    = 16;
	localparam int          TIMEOUT_CHARS = 4;
	localparam logic [9:0]  TO_TICKS_BIT  = 10'(TIMEOUT_CHARS * OVERSAMPLE);
	localparam logic [9:0]  FRAME_FIXED   = 10'h007;
	localparam logic [3:0][4:0] RX_TRIG   = {5'h0e, 5'h08, 5'h04, 5'h01};

	// ********************************************************
	// Types
	// ********************************************************
	typedef struct packed {
		logic       msIrqEn;
		logic [1:0] trig;
		logic       dma_mode_select;
		logic       fifo_enable_bit;
		logic       sp;
		logic       eps;
		logic       pen;
		logic [1:0] wls;
	} ulmds_cfg_t;

	typedef struct packed {
		logic       brk;
		logic       frm;
		logic       par;
		logic [7:0] data;
	} ulmds_char_t;

	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BREAK}
		ulmds_rx_state_t;

	typedef struct packed {
		ulmds_rx_state_t state;
		logic [3:0]      tick;
		logic [2:0]      bitIdx;
		logic [7:0]      shift;
		logic            parAcc;
		logic            zeros;
		logic            parErr;
		logic            valid;
		ulmds_char_t     chr;
	} ulmds_rxs_t;

	typedef struct packed {
		ulmds_cfg_t                        cfg;
		logic [7:0]                        scratch;
		ulmds_char_t [FIFO_DEPTH-1:0]      mem;
		logic [3:0]                        wp;
		logic [3:0]                        rp;
		logic [4:0]                        cnt;
		logic [4:0]                        errCnt;
		logic                              rx_fifo_error_flag;
		logic                              brk;
		logic                              frm;
		logic                              par;
		logic                              ovr;
		logic                              cts;
		logic                              clear_to_send_changed;
		logic                              msIrq;
		logic                              tx_holding_empty_flag;
		logic                              tx_all_empty_flag;
		logic                              tx_dma_ready_flag;
		logic                              rx_dma_ready_flag;
		logic                              timeout;
		logic                              fenPrev;
		logic [9:0]                        toCnt;
		logic                              pready;
		logic                              pslverr;
		logic [31:0]                       prdata;
	} ulmds_st_t;
endpackage : ulmds_pkg

// ==== rtl/ulmds_rx_sampler.sv ====
`timescale 1ns/1ps
module ulmds_rx_sampler
	import ulmds_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        baudTick,
	input  wire logic        serialIn,
	input  wire ulmds_cfg_t  cfg,
	output logic             chrValid,
	output ulmds_char_t      chrOut
);
	ulmds_rxs_t s_r;
	ulmds_rxs_t s_nxt;
	logic       expPar;

	assign chrValid = s_r.valid;
	assign chrOut   = s_r.chr;
	assign expPar   = cfg.sp ? !cfg.eps : (cfg.eps ? s_r.parAcc : !s_r.parAcc);

	always_comb begin
		s_nxt       = s_r;
		s_nxt.valid = 1'b0;
		if (baudTick) begin
			s_nxt.tick = s_r.tick + 4'h1;
			unique case (s_r.state)
				RX_IDLE: begin
					if (!serialIn) begin
						s_nxt.state = RX_START;
						s_nxt.tick  = 4'h0;
					end
				end
				RX_START: begin
					if (s_r.tick == TICK_MID) begin
						s_nxt.state  = serialIn ? RX_IDLE : RX_DATA;
						s_nxt.tick   = 4'h0;
						s_nxt.bitIdx = 3'h0;
						s_nxt.zeros  = 1'b1;
						s_nxt.parAcc = 1'b0;
					end
				end
				RX_DATA: begin
					if (s_r.tick == TICK_LAST) begin
						s_nxt.shift  = {serialIn, s_r.shift[7:1]};
						s_nxt.parAcc = s_r.parAcc ^ serialIn;
						s_nxt.zeros  = s_r.zeros & !serialIn;
						s_nxt.bitIdx = s_r.bitIdx + 3'h1;
						if (s_r.bitIdx == 3'h4 + {1'b0, cfg.wls}) begin
							s_nxt.state = cfg.pen ? RX_PAR : RX_STOP;
						end
					end
				end
				RX_PAR: begin
					if (s_r.tick == TICK_LAST) begin
						s_nxt.parErr = serialIn != expPar; // R10
						s_nxt.zeros  = s_r.zeros & !serialIn;
						s_nxt.state  = RX_STOP;
					end
				end
				RX_STOP: begin
					if (s_r.tick == TICK_LAST) begin
						s_nxt.valid    = 1'b1;
						s_nxt.chr.data = s_r.shift >> (2'h3 - cfg.wls);
						s_nxt.chr.brk  = 1'b0;
						s_nxt.chr.frm  = !serialIn; // R7
						s_nxt.chr.par  = cfg.pen && s_r.parErr;
						s_nxt.parErr   = 1'b0;
						if (!serialIn && s_r.zeros) begin
							// Whole frame low: one zero character, then park
							s_nxt.chr   = '{brk: 1'b1, frm: 1'b0, par: 1'b0, data: 8'h00}; // R4
							s_nxt.state = RX_BREAK; // R5
						end else if (!serialIn) begin
							// Low stop sample sits mid start bit of the next frame
							s_nxt.state  = RX_DATA; // R8
							s_nxt.bitIdx = 3'h0;
							s_nxt.zeros  = 1'b1;
							s_nxt.parAcc = 1'b0;
						end else begin
							s_nxt.state = RX_IDLE;
						end
					end
				end
				RX_BREAK: begin
					if (serialIn) begin
						s_nxt.state = RX_IDLE; // R5
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			s_r <= '{state: RX_IDLE, tick: 4'h0, bitIdx: 3'h0, shift: 8'h00,
				parAcc: 1'b0, zeros: 1'b0, parErr: 1'b0, valid: 1'b0, chr: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);

	break_park_a: assert property (s_r.state == RX_BREAK && !serialIn |=> s_r.state == RX_BREAK) // R5
		else $error("break state left while line low");
	frame_resync_a: assert property (baudTick && s_r.state == RX_STOP && s_r.tick == TICK_LAST
		&& !serialIn && !s_r.zeros |=> s_r.state == RX_DATA && s_r.valid && s_r.chr.frm) // R8
		else $error("no resync after framing error");
endmodule : ulmds_rx_sampler

// ==== rtl/ulmds_status.sv ====
`timescale 1ns/1ps
module ulmds_status
	import ulmds_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        baudTick,
	input  wire logic        serialIn,
	input  wire logic        ctsN,
	input  wire logic        txHoldFull,
	input  wire logic [4:0]  txFifoCount,
	input  wire logic        txShiftBusy,
	output logic             modemIrq
);
	ulmds_st_t   s_r;
	ulmds_st_t   s_nxt;
	logic        chrValid;
	ulmds_char_t chrIn;
	logic        setup;
	logic        done;
	logic        rdTake;
	logic        wrDone;
	logic        rdLsr;
	logic        rdMsr;
	logic        mode1;
	logic [4:0]  depth;
	logic        pop;
	logic        room;
	logic        push;
	logic        ovwr;
	ulmds_char_t head;
	ulmds_char_t newHead;
	logic        loadHead;
	logic [4:0]  trigLvl;
	logic [9:0]  toLimit;
	logic        txOcc;
	logic [7:0]  lsrVal;

	assign pready   = s_r.pready;
	assign prdata   = s_r.prdata;
	assign pslverr  = s_r.pslverr;
	assign modemIrq = s_r.msIrq;

	ulmds_rx_sampler u_rx (
		.clock    (clock),
		.nrst     (nrst),
		.baudTick (baudTick),
		.serialIn (serialIn),
		.cfg      (s_r.cfg),
		.chrValid (chrValid),
		.chrOut   (chrIn)
	);

	// ********************************************************
	// Bus decode
	// ********************************************************
	// Read side effects happen at the setup edge, where the data is captured,
	// so an event landing between capture and completion is never cleared unseen.
	assign setup  = psel && !penable;
	assign done   = psel && penable && s_r.pready;
	assign rdTake = setup && !pwrite;
	assign wrDone = done && pwrite;
	assign rdLsr  = rdTake && paddr == OFF_LSR;
	assign rdMsr  = rdTake && paddr == OFF_MSR;

	// ********************************************************
	// Receive buffer / FIFO
	// ********************************************************
	assign mode1    = s_r.cfg.dma_mode_select && s_r.cfg.fifo_enable_bit; // R17
	assign depth    = s_r.cfg.fifo_enable_bit ? FIFO_FULL : NOFIFO_DEPTH;
	assign pop      = rdTake && paddr == OFF_RBR && s_r.cnt != 5'h00;
	assign room     = s_r.cnt < depth || pop;
	assign push     = chrValid && room;
	assign ovwr     = chrValid && !room && !s_r.cfg.fifo_enable_bit; // R11
	assign head     = s_r.mem[s_r.rp];
	assign newHead  = (pop && s_r.cnt > 5'h01) ? s_r.mem[s_r.rp + 4'h1] : chrIn;
	assign loadHead = (push && (s_r.cnt == 5'h00 || (pop && s_r.cnt == 5'h01)))
		|| (pop && s_r.cnt > 5'h01) || ovwr;
	assign trigLvl  = RX_TRIG[s_r.cfg.trig]; // R23
	assign toLimit  = 10'((FRAME_FIXED + 10'(s_r.cfg.wls) + 10'(s_r.cfg.pen)) * TO_TICKS_BIT);
	assign txOcc    = s_r.cfg.fifo_enable_bit ? txFifoCount != 5'h00 : txHoldFull;
	assign lsrVal   = {s_r.cnt != 5'h00, s_r.ovr, s_r.par, s_r.frm, s_r.brk, // R13
		s_r.tx_holding_empty_flag, s_r.tx_all_empty_flag, s_r.rx_fifo_error_flag};

	always_comb begin
		s_nxt         = s_r;
		s_nxt.pready  = 1'b0;
		s_nxt.pslverr = 1'b0;
		s_nxt.fenPrev = s_r.cfg.fifo_enable_bit;

		if (pop) begin
			s_nxt.rp     = s_r.rp + 4'h1;
			s_nxt.errCnt = s_nxt.errCnt - {4'h0, head.brk | head.frm | head.par};
		end
		if (push) begin
			s_nxt.mem[s_r.wp] = chrIn;
			s_nxt.wp          = s_r.wp + 4'h1;
			s_nxt.errCnt      = s_nxt.errCnt + {4'h0, chrIn.brk | chrIn.frm | chrIn.par};
		end
		if (ovwr) begin
			s_nxt.mem[s_r.rp] = chrIn;
		end
		s_nxt.cnt = s_r.cnt + {4'h0, push} - {4'h0, pop};
		// Switching FIFO mode drops everything buffered
		if (s_r.cfg.fifo_enable_bit != s_r.fenPrev) begin
			s_nxt.wp     = 4'h0;
			s_nxt.rp     = 4'h0;
			s_nxt.cnt    = 5'h00;
			s_nxt.errCnt = 5'h00;
		end

		// ****************************************************
		// Line status flags: clears first, so sets win
		// ****************************************************
		if (rdLsr) begin
			s_nxt.brk = 1'b0; // R6
			s_nxt.frm = 1'b0; // R9
			s_nxt.par = 1'b0; // R10
			s_nxt.ovr = 1'b0; // R11
		end
		if (chrValid && !chrIn.brk && !chrIn.frm) begin
			s_nxt.brk = 1'b0; // R6
		end
		if (loadHead) begin
			s_nxt.frm = newHead.frm; // R7 R9
			s_nxt.par = newHead.par; // R10
			s_nxt.brk = s_nxt.brk | newHead.brk; // R4 R5
		end
		if (chrValid && !room) begin
			s_nxt.ovr = 1'b1; // R11 R12
		end
		if (rdLsr && s_nxt.errCnt == 5'h00) begin
			s_nxt.rx_fifo_error_flag = 1'b0; // R1
		end
		if (!s_r.cfg.fifo_enable_bit) begin
			s_nxt.rx_fifo_error_flag = 1'b0;
		end else if (s_nxt.errCnt != 5'h00) begin
			s_nxt.rx_fifo_error_flag = 1'b1; // R1
		end
		s_nxt.tx_holding_empty_flag = s_r.cfg.fifo_enable_bit ? txFifoCount == 5'h00 : !txHoldFull; // R3
		s_nxt.tx_all_empty_flag = s_nxt.tx_holding_empty_flag && !txShiftBusy; // R2

		// ****************************************************
		// Modem status
		// ****************************************************
		s_nxt.cts = !ctsN; // R14
		if (rdMsr) begin
			s_nxt.clear_to_send_changed = 1'b0;
		end
		if (s_nxt.cts != s_r.cts) begin
			s_nxt.clear_to_send_changed = 1'b1; // R15
		end
		s_nxt.msIrq = s_nxt.clear_to_send_changed && s_r.cfg.msIrqEn; // R15

		// ****************************************************
		// Receive timeout in baud ticks
		// ****************************************************
		if (s_nxt.cnt == 5'h00 || push || pop) begin
			s_nxt.toCnt   = 10'h000; // R24
			s_nxt.timeout = 1'b0;
		end else if (baudTick && !s_r.timeout) begin
			if (s_r.toCnt == toLimit - 10'h001) begin
				s_nxt.timeout = 1'b1; // R24
			end else begin
				s_nxt.toCnt = s_r.toCnt + 10'h001;
			end
		end

		// ****************************************************
		// DMA ready
		// ****************************************************
		if (!mode1) begin
			s_nxt.tx_dma_ready_flag = txOcc; // R18
			s_nxt.rx_dma_ready_flag = s_nxt.cnt == 5'h00; // R20
		end else begin
			if (!txOcc) begin
				s_nxt.tx_dma_ready_flag = 1'b0; // R19
			end else if (txFifoCount == FIFO_FULL) begin
				s_nxt.tx_dma_ready_flag = 1'b1; // R19
			end
			if (s_nxt.cnt == 5'h00) begin
				s_nxt.rx_dma_ready_flag = 1'b1; // R21
			end else if (s_nxt.cnt >= trigLvl || s_nxt.timeout) begin
				s_nxt.rx_dma_ready_flag = 1'b0; // R21
			end
		end

		// ****************************************************
		// APB slave: zero wait states, answer registered
		// ****************************************************
		if (setup) begin
			s_nxt.pready = 1'b1;
			s_nxt.prdata = 32'h0000_0000;
			unique case (paddr)
				OFF_RBR: s_nxt.prdata[7:0] = s_r.cnt != 5'h00 ? head.data : 8'h00;
				OFF_LSR: s_nxt.prdata[7:0] = lsrVal;
				OFF_MSR: begin
					s_nxt.prdata[MSR_CTS]  = s_r.cts;
					s_nxt.prdata[MSR_CLEAR_TO_SEND_CHANGED] = s_r.clear_to_send_changed;
				end
				OFF_SCR: s_nxt.prdata[7:0] = s_r.scratch;
				OFF_DSR: begin
					s_nxt.prdata[DSR_TX] = s_r.tx_dma_ready_flag;
					s_nxt.prdata[DSR_RX] = s_r.rx_dma_ready_flag;
				end
				OFF_CFG: s_nxt.prdata[9:0] = s_r.cfg;
				default: s_nxt.pslverr = 1'b1;
			endcase
		end
		if (wrDone && paddr == OFF_SCR) begin
			s_nxt.scratch = pwdata[7:0]; // R16
		end
		if (wrDone && paddr == OFF_CFG) begin
			s_nxt.cfg = pwdata[9:0];
			// Entering mode 1 part-filled must not inherit the mode 0 ready
			if (!mode1 && s_nxt.cfg.dma_mode_select && s_nxt.cfg.fifo_enable_bit) begin
				s_nxt.tx_dma_ready_flag = 1'b0; // R19
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			s_r         <= '0;
			s_r.cfg     <= CFG_RST;
			s_r.scratch <= SCR_RST;
			s_r.tx_holding_empty_flag    <= 1'b1;
			s_r.tx_all_empty_flag    <= 1'b1;
			s_r.rx_dma_ready_flag   <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);

	tx_all_empty_flag_tx_holding_empty_flag_a: assert property (s_r.tx_all_empty_flag |-> s_r.tx_holding_empty_flag && !$past(txShiftBusy)) // R2
		else $error("transmitter empty while busy");
	ovr_clear_a: assert property (rdLsr && !chrValid |=> !s_r.ovr) // R11
		else $error("overrun not cleared by status read");
	cts_invert_a: assert property (##1 s_r.cts == !$past(ctsN)) // R14
		else $error("clear-to-send bit not inverse of pin");
	clear_to_send_changed_change_a: assert property (s_r.cts != $past(s_r.cts) |-> s_r.clear_to_send_changed) // R15
		else $error("clear-to-send change not flagged");
	irq_gate_a: assert property (s_r.msIrq |-> s_r.clear_to_send_changed && s_r.cfg.msIrqEn) // R15
		else $error("modem interrupt without enabled change");
	fifo_keep_a: assert property (s_r.cfg.fifo_enable_bit && s_r.cnt == FIFO_FULL && chrValid && !pop
		&& s_r.cfg.fifo_enable_bit == s_r.fenPrev |=> s_r.cnt == FIFO_FULL && s_r.ovr
		&& $stable(s_r.mem)) // R12
		else $error("full FIFO altered on overrun");
	rx_mode0_a: assert property (!mode1 && !$past(mode1)
		|-> s_r.rx_dma_ready_flag == (s_r.cnt == 5'h00)) // R20
		else $error("mode 0 receive-ready wrong");
	rx_mode1_a: assert property (mode1 && s_r.cnt != 5'h00 && s_r.cnt >= trigLvl
		&& $stable(s_r.cfg) |-> !s_r.rx_dma_ready_flag) // R21
		else $error("mode 1 receive-ready set at trigger");
	tx_mode1_a: assert property (mode1 && $past(mode1) && !s_r.tx_dma_ready_flag && txFifoCount != FIFO_FULL
		&& txFifoCount != 5'h00 |=> !s_r.tx_dma_ready_flag || $past(txFifoCount) == FIFO_FULL) // R19
		else $error("mode 1 transmit-ready set before full");
	dr_level_a: assert property (pop && s_r.cnt == 5'h01 && !chrValid |=> !lsrVal[7]) // R13
		else $error("data ready stays after last character read");
endmodule : ulmds_status

// ==== verification/ulmds_peer_model.sv ====
`timescale 1ns/1ps
// ****************************************
// Serial peer on the far side of the receive line
// ****************************************
module ulmds_peer_model (
	input  wire logic clock,
	input  wire logic baudTick,
	output logic      serialIn,
	output logic      ctsN
);
	// Idle line sits at mark level, clear-to-send negated
	initial begin
		serialIn = 1'b1;
		ctsN     = 1'b1;
	end

	// One bit cell lasts sixteen baud ticks; the line only moves just after an edge
	task automatic lineBit(input logic v);
		serialIn <= v;
		repeat (16) @(posedge clock iff baudTick);
	endtask : lineBit

	// Start, eight data bits LSB first, optional parity, stop, then one idle cell
	task automatic sendFrame(input logic [7:0] d, input logic hasPar, input logic parBit,
		input logic stopBit);
		lineBit(1'b0);
		for (int i = 0; i < 8; i++)
			lineBit(d[i]);
		if (hasPar)
			lineBit(parBit);
		lineBit(stopBit);
		lineBit(1'b1);
	endtask : sendFrame

	// Line held low for whole bit cells, then released to mark
	task automatic holdLow(input int nBits);
		repeat (nBits) lineBit(1'b0);
		lineBit(1'b1);
	endtask : holdLow

	task automatic idleBits(input int nBits);
		repeat (nBits) lineBit(1'b1);
	endtask : idleBits

	task automatic setCts(input logic v);
		ctsN <= v;
	endtask : setCts
endmodule : ulmds_peer_model

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %s expected %h seen %h", nm, e, g); end end
module tb
	import ulmds_pkg::*;
;
	typedef struct packed {
		logic        err;
		logic [31:0] data;
		logic [31:0] mask;
	} ulmds_exp_t;

	logic        clock = 1'b0;
	logic        nrst, psel, penable, pwrite, txHoldFull, txShiftBusy, p;
	logic        baudTick = 1'b0;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, d;
	logic [4:0]  txFifoCount;
	logic        pready, pslverr, modemIrq, serialIn, ctsN;
	logic [7:0]  b0, b1;
	logic [7:0]  fifoData [17];
	ulmds_exp_t  expQ [$];
	ulmds_exp_t  expNow;
	int          n_mismatch = 0;
	int          num_checks = 0;
	integer      seed = 32'h34beb7b9;
	logic [9:0]  tCfg [8] = '{10'h003, 10'h003, 10'h043, 10'h023, 10'h063, 10'h063, 10'h063, 10'h063};
	logic [4:0]  tCnt [8] = '{5'h00, 5'h00, 5'h00, 5'h03, 5'h05, 5'h10, 5'h05, 5'h00};
	logic [1:0]  tHs  [8] = '{2'h2, 2'h1, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0};
	// Expected holding-empty, all-empty, transmit-ready per row
	logic [2:0]  tExp [8] = '{3'h1, 3'h4, 3'h1, 3'h1, 3'h0, 3'h1, 3'h1, 3'h6};
	logic [9:0]  pCfg [4] = '{10'h027, 10'h02f, 10'h037, 10'h03f};

	ulmds_status ulmds_status_i (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .baudTick(baudTick), .serialIn(serialIn), .ctsN(ctsN),
		.txHoldFull(txHoldFull), .txFifoCount(txFifoCount), .txShiftBusy(txShiftBusy),
		.modemIrq(modemIrq));
	ulmds_peer_model ulmds_peer_model_i (.clock(clock), .baudTick(baudTick),
		.serialIn(serialIn), .ctsN(ctsN));

	always #2 clock = ~clock;
	// Baud enable every second clock keeps frames short
	always @(posedge clock) baudTick <= ~baudTick;

	// ****************************************
	// Response monitor
	// ****************************************
	always @(posedge clock) begin
		if (nrst === 1'b1 && psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
			if (expQ.size() == 0)
				`CHK("response", 1'b0, 1'b1)
			else begin
				expNow = expQ.pop_front();
				`CHK("pslverr", expNow.err, pslverr)
				`CHK("prdata", expNow.data & expNow.mask, prdata & expNow.mask)
			end
		end
	end

	// ****************************************
	// Bus tasks
	// ****************************************
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		input logic [31:0] ed, input logic [31:0] em, input logic ee);
		int n;
		@(posedge clock);
		expQ.push_back('{ee, ed, em});
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			n_mismatch++;
			$display("BAD pready expected 1 seen %b", pready);
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = 32'hff);
		apb(1'b0, a, 32'h0, e, m, 1'b0);
	endtask : rd

	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		apb(1'b1, a, v, 32'h0, 32'h0, 1'b0);
	endtask : wr

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish

	// Watchdog sized well above the expected run of about 14000 cycles
	initial begin
		repeat (60000) @(posedge clock);
		n_mismatch++;
		tally_and_finish();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		nrst = 1'b0;
		{psel, penable, pwrite, txHoldFull, txShiftBusy} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		txFifoCount = 5'h00;
		repeat (8) @(posedge clock);
		nrst <= 1'b1;
		rd(OFF_LSR, 32'h06);
		rd(OFF_DSR, 32'h80, 32'hc0);
		rd(OFF_MSR, 32'h00);
		rd(OFF_SCR, {24'h0, SCR_RST});
		d = $random(seed);
		wr(OFF_SCR, d);
		rd(OFF_SCR, {24'h0, d[7:0]}, 32'hffffffff);
		wr(OFF_LSR, 32'hff);
		rd(OFF_LSR, 32'h06);
		apb(1'b0, 12'h018, 32'h0, 32'h0, 32'h0, 1'b1);
		apb(1'b1, 12'h018, d, 32'h0, 32'h0, 1'b1);
		ulmds_peer_model_i.setCts(1'b0);
		repeat (3) @(posedge clock);
		rd(OFF_MSR, 32'h88);
		rd(OFF_MSR, 32'h08);
		wr(OFF_CFG, 32'h203);
		ulmds_peer_model_i.setCts(1'b1);
		repeat (3) @(posedge clock);
		`CHK("modemIrq", 1'b1, modemIrq)
		rd(OFF_MSR, 32'h80);
		repeat (2) @(posedge clock);
		`CHK("modemIrq", 1'b0, modemIrq)
		// Transmit side status per mode and fill level
		for (int i = 0; i < 8; i++) begin
			wr(OFF_CFG, {22'h0, tCfg[i]});
			txHoldFull <= tHs[i][1];
			txShiftBusy <= tHs[i][0];
			txFifoCount <= (tCnt[i] == 5'h05) ? 5'(1 + {$random(seed)} % 15) : tCnt[i];
			repeat (3) @(posedge clock);
			rd(OFF_LSR, {29'h0, tExp[i][2:1], 1'b0}, 32'h06);
			rd(OFF_DSR, {24'h0, 1'b1, tExp[i][0], 6'h0}, 32'hc0);
		end
		// Single buffer: receive, readiness, overrun
		wr(OFF_CFG, 32'h003);
		b0 = $random(seed);
		b1 = $random(seed);
		ulmds_peer_model_i.sendFrame(b0, 1'b0, 1'b0, 1'b1);
		rd(OFF_DSR, 32'h00, 32'h80);
		rd(OFF_LSR, 32'h86);
		rd(OFF_RBR, {24'h0, b0});
		rd(OFF_LSR, 32'h06);
		ulmds_peer_model_i.sendFrame(b0, 1'b0, 1'b0, 1'b1);
		ulmds_peer_model_i.sendFrame(b1, 1'b0, 1'b0, 1'b1);
		rd(OFF_LSR, 32'hc6);
		rd(OFF_LSR, 32'h86);
		rd(OFF_RBR, {24'h0, b1});
		// Every parity mode: good character then a bad one
		for (int m = 0; m < 4; m++) begin
			wr(OFF_CFG, {22'h0, pCfg[m]});
			b0 = $random(seed);
			b1 = $random(seed);
			p = (m == 0) ? ~^b0 : (m == 1) ? ^b0 : (m == 2);
			ulmds_peer_model_i.sendFrame(b0, 1'b1, p, 1'b1);
			p = (m == 0) ? ~^b1 : (m == 1) ? ^b1 : (m == 2);
			ulmds_peer_model_i.sendFrame(b1, 1'b1, ~p, 1'b1);
			rd(OFF_LSR, 32'h87);
			rd(OFF_RBR, {24'h0, b0});
			rd(OFF_LSR, 32'ha7);
			rd(OFF_RBR, {24'h0, b1});
			rd(OFF_LSR, 32'h06, 32'hfe);
			rd(OFF_LSR, 32'h06);
		end
		// Short word: five data bits, the upper cells stay at mark
		wr(OFF_CFG, 32'h020);
		ulmds_peer_model_i.sendFrame(b0 | 8'he0, 1'b0, 1'b0, 1'b1);
		rd(OFF_RBR, {27'h0, b0[4:0]});
		// Framing error with resync, then a break; a nonzero character stays a framing error
		b0[0] = 1'b1;
		wr(OFF_CFG, 32'h023);
		ulmds_peer_model_i.sendFrame(b0, 1'b0, 1'b0, 1'b0);
		ulmds_peer_model_i.idleBits(10);
		rd(OFF_LSR, 32'h97);
		rd(OFF_RBR, {24'h0, b0});
		rd(OFF_LSR, 32'h86, 32'hfe);
		rd(OFF_RBR, 32'hff);
		rd(OFF_LSR, 32'h06);
		ulmds_peer_model_i.holdLow(11);
		rd(OFF_LSR, 32'h8f);
		rd(OFF_RBR, 32'h00);
		rd(OFF_LSR, 32'h06, 32'hfe);
		ulmds_peer_model_i.sendFrame(b1, 1'b0, 1'b0, 1'b1);
		rd(OFF_LSR, 32'h86);
		rd(OFF_RBR, {24'h0, b1});
		// Fill past full with trigger four, then drain
		wr(OFF_CFG, 32'h0e3);
		rd(OFF_DSR, 32'h80, 32'h80);
		for (int i = 0; i < 17; i++) begin
			fifoData[i] = $random(seed);
			ulmds_peer_model_i.sendFrame(fifoData[i], 1'b0, 1'b0, 1'b1);
			if (i == 2)
				rd(OFF_DSR, 32'h80, 32'h80);
			if (i == 3)
				rd(OFF_DSR, 32'h00, 32'h80);
		end
		rd(OFF_LSR, 32'hc6);
		for (int i = 0; i < 16; i++) begin
			rd(OFF_RBR, {24'h0, fifoData[i]});
			if (i == 13)
				rd(OFF_DSR, 32'h00, 32'h80);
		end
		rd(OFF_DSR, 32'h80, 32'h80);
		rd(OFF_LSR, 32'h06);
		// Idle character with trigger fourteen must time out
		wr(OFF_CFG, 32'h1e3);
		ulmds_peer_model_i.sendFrame(b0, 1'b0, 1'b0, 1'b1);
		rd(OFF_DSR, 32'h80, 32'h80);
		repeat (1400) @(posedge clock);
		rd(OFF_DSR, 32'h00, 32'h80);
		rd(OFF_RBR, {24'h0, b0});
		rd(OFF_DSR, 32'h80, 32'h80);
		repeat (4) @(posedge clock);
		tally_and_finish();
	end
endmodule : tb
